/* File: include/mcs_pkg.sv */
// Constants and carrier types for the monitor configuration/status block
// Operation
// - Writing 1 to config bit 7 restores writable registers to defaults.
// - Config bit 6 at 1 drives the general output pin low.
// - Config bit 5 clears the intrusion latch, self-clears after 10 ms.
// - Config bit 4 at 1 gives an active-low reset pulse of 10 ms.
// - With 0x05 bits 7/6 = 1/0, reset bit clears after pulse ends.
// - Config bit 3 disables the alert output, status left unchanged.
// - Suppress bit halts temperature and voltage monitoring until cleared.
// - Config bit 2 selects alert level: 1 active high, 0 active low.
// - Alert output enabled only while config bit 1 is 1.
// - Config bit 0 runs all monitoring; 0 means shutdown.
// - Status one bit 7 sets on a low external alert input.
// - Status one bits 6..0 set on voltage channel limit violation.
// - Status two bit 5 sets when temperature passes shutdown limits.
// - Shutdown flag interrupt mode follows register 0x04 bit 7.
// - Status two bit 4 sets when intrusion input has gone high.
// - Status two bits 3 and 2 flag fan two and fan one.
// - Status two bit 1 flags a board temperature input interrupt.
// - Status two bit 0 sets when temperature passes its limits.
// - Temperature flag interrupt mode follows register 0x04 bit 6.
// - Fan flagged when measured period count exceeds programmed limit.
// - Mask bit at 1 keeps its status bit off the alert.
package mcs_pkg;

  // Register offsets
  localparam logic [7:0] CFG_OFFSET   = 8'h00;
  localparam logic [7:0] STAT1_OFFSET = 8'h01;
  localparam logic [7:0] STAT2_OFFSET = 8'h02;

  // Configuration fields
  localparam int CFG_RESTORE_BIT = 7;
  localparam int CFG_GPO_BIT     = 6;
  localparam int CFG_CHCLR_BIT   = 5;
  localparam int CFG_RSTP_BIT    = 4;
  localparam int CFG_SUPP_BIT    = 3;
  localparam int CFG_POL_BIT     = 2;
  localparam int CFG_EN_BIT      = 1;
  localparam int CFG_START_BIT   = 0;

  // Status fields
  localparam int STAT1_ALERT_IN_BIT = 7;
  localparam int STAT2_OVERTEMP_SHUTDOWN_FLAG       = 5;
  localparam int STAT2_INTR_BIT     = 4;
  localparam int STAT2_FAN2_BIT     = 3;
  localparam int STAT2_FAN1_BIT     = 2;
  localparam int STAT2_BTI_BIT      = 1;
  localparam int STAT2_TEMP_BIT     = 0;
  localparam int STAT2_USED_W       = 6;

  // Neighbour register fields (mask two, pin configuration)
  localparam int MASK2_OS_MODE_BIT   = 7;
  localparam int MASK2_TEMP_MODE_BIT = 6;
  localparam int PINCFG_HI_BIT       = 7;
  localparam int PINCFG_LO_BIT       = 6;

  // Values after reset
  localparam logic [7:0] CFG_RESET  = 8'h08;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // Timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int PULSE_TIME_MS = 10;
  localparam int PULSE_CYCLES  = (PULSE_TIME_MS * CLK_HZ + 999) / 1000;

  // Register access request from the serial interface engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcs_reg_req_type;

  // Limit comparison results from the conversion engine
  typedef struct packed {
    logic       valid;
    logic [6:0] volt_out;
    logic       temp_out;
    logic       os_out;
  } mcs_limit_type;

endpackage

/* File: hdl/mcs_pulse_timer.sv */
// Retriggerable fixed-length pulse timer
`timescale 1ns/1ps
module mcs_pulse_timer
  import mcs_pkg::*;
#(
  parameter int unsigned CYCLES = PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic start_i,
  // Status
  output logic      busy_o,
  output logic      done_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Load on start, then count down to zero
  always_comb begin
    cnt_d = cnt_q;
    if (start_i) begin
      cnt_d = LOAD;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - ONE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = (cnt_q != '0);
  assign done_o = (cnt_q == ONE) && !start_i;

endmodule

/* File: hdl/mcs_regs.sv */
// Configuration and limit-status registers of the hardware monitor
`timescale 1ns/1ps
module mcs_regs
  import mcs_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES,
  parameter int          FAN_W     = 8
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // Register access from the serial engine
  input  wire mcs_reg_req_type      reg_req_i,
  output logic [7:0]                reg_rdata_o,
  // Neighbour registers held elsewhere
  input  wire logic [7:0]           mask_volt_i,
  input  wire logic [7:0]           mask_therm_i,
  input  wire logic [7:0]           pin_cfg_i,
  // Conversion and fan measurement results
  input  wire mcs_limit_type        limits_i,
  input  wire logic [1:0]           fan_valid_i,
  input  wire logic [1:0][FAN_W-1:0] fan_count_i,
  input  wire logic [1:0][FAN_W-1:0] fan_limit_i,
  // Device pins in
  input  wire logic                 alert_in_n_i,
  input  wire logic                 intrusion_input_i,
  input  wire logic                 board_temp_alert_n_i,
  // Device pins out
  output logic                      alert_o,
  output logic                      general_output_pin_o,
  output logic                      reset_out_n_o,
  // Control to the monitoring engines
  output logic                      volt_temp_run_o,
  output logic                      fan_run_o,
  output logic                      defaults_restore_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [2:0] pin_raw;
  logic       alert_in_low;
  logic       intrusion_high;
  logic       bti_low;

  assign pin_raw = {board_temp_alert_n_i, intrusion_input_i, alert_in_n_i};

  // Two stages reset to idle levels, so no false latch follows reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 3'h5;
      pin_sync_q <= 3'h5;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign alert_in_low   = !pin_sync_q[0];
  assign intrusion_high = pin_sync_q[1];
  assign bti_low        = !pin_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  logic wr_cfg;
  logic rd_stat1;
  logic rd_stat2;

  assign wr_cfg   = reg_req_i.wr && (reg_req_i.addr == CFG_OFFSET);
  assign rd_stat1 = reg_req_i.rd && (reg_req_i.addr == STAT1_OFFSET);
  assign rd_stat2 = reg_req_i.rd && (reg_req_i.addr == STAT2_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Timed pulses

  logic chclr_start;
  logic chclr_busy;
  logic chclr_done;
  logic rstp_start;
  logic rstp_busy;
  logic rstp_done;
  logic [7:0] cfg_q;

  assign chclr_start = wr_cfg && reg_req_i.wdata[CFG_CHCLR_BIT]
                       && !reg_req_i.wdata[CFG_RESTORE_BIT];

  // pulse start
  // A second request during a running pulse is ignored, not stretched
  assign rstp_start = wr_cfg && reg_req_i.wdata[CFG_RSTP_BIT]
                      && !reg_req_i.wdata[CFG_RESTORE_BIT] && !rstp_busy;

  mcs_pulse_timer #(
    .CYCLES (PULSE_LEN)
  ) u_chclr_timer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (chclr_start),
    .busy_o    (chclr_busy),
    .done_o    (chclr_done)
  );

  mcs_pulse_timer #(
    .CYCLES (PULSE_LEN)
  ) u_rstp_timer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (rstp_start),
    .busy_o    (rstp_busy),
    .done_o    (rstp_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  logic [7:0] cfg_d;
  logic       restore_q;
  logic       restore_d;
  logic       auto_rstp_clr;

  assign auto_rstp_clr = pin_cfg_i[PINCFG_HI_BIT] && !pin_cfg_i[PINCFG_LO_BIT];

  always_comb begin
    cfg_d     = cfg_q;
    restore_d = 1'b0;
    if (wr_cfg) begin
      if (reg_req_i.wdata[CFG_RESTORE_BIT]) begin
        cfg_d     = CFG_RESET;
        restore_d = 1'b1;
      end else begin
        cfg_d = reg_req_i.wdata;
        // bit only set by a write
        cfg_d[CFG_CHCLR_BIT] = reg_req_i.wdata[CFG_CHCLR_BIT]
                               || cfg_q[CFG_CHCLR_BIT];
      end
    end
    if (chclr_done) begin
      cfg_d[CFG_CHCLR_BIT] = 1'b0;
    end
    // reset bit drops when pulse ends, only while auto_rstp_clr is set
    if (rstp_done && auto_rstp_clr && !rstp_start) begin
      cfg_d[CFG_RSTP_BIT] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_q     <= CFG_RESET;
      restore_q <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      restore_q <= restore_d;
    end
  end

  assign defaults_restore_o = restore_q;

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring run control

  logic vt_run;
  logic fan_run;

  assign vt_run  = cfg_q[CFG_START_BIT] && !cfg_q[CFG_SUPP_BIT];
  assign fan_run = cfg_q[CFG_START_BIT];

  assign volt_temp_run_o = vt_run;
  assign fan_run_o       = fan_run;

  ////////////////////////////////////////////////////////////////////////////
  // Status register one

  logic [7:0] stat1_q;
  logic [7:0] stat1_d;

  // Read clears, and a set in the same cycle wins
  always_comb begin
    stat1_d = stat1_q;
    if (rd_stat1) begin
      stat1_d = STAT_RESET;
    end
    if (alert_in_low) begin
      stat1_d[STAT1_ALERT_IN_BIT] = 1'b1;
    end
    if (limits_i.valid && vt_run) begin
      stat1_d[6:0] = stat1_d[6:0] | limits_i.volt_out;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stat1_q <= STAT_RESET;
    end else begin
      stat1_q <= stat1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register two

  logic [STAT2_USED_W-1:0] stat2_q;
  logic [STAT2_USED_W-1:0] stat2_d;
  logic                    conv_ok;
  logic                    os_sticky;
  logic                    temp_sticky;
  logic [1:0]              fan_over;

  assign conv_ok     = limits_i.valid && vt_run;
  assign os_sticky   = mask_therm_i[MASK2_OS_MODE_BIT];
  assign temp_sticky = mask_therm_i[MASK2_TEMP_MODE_BIT];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      fan_over[i] = fan_valid_i[i] && fan_run
                    && (fan_count_i[i] > fan_limit_i[i]);
    end
  end

  always_comb begin
    stat2_d = stat2_q;
    if (rd_stat2) begin
      stat2_d[STAT2_FAN2_BIT] = 1'b0;
      stat2_d[STAT2_FAN1_BIT] = 1'b0;
      stat2_d[STAT2_BTI_BIT]  = 1'b0;
    end
    if (os_sticky) begin
      if (rd_stat2) begin
        stat2_d[STAT2_OVERTEMP_SHUTDOWN_FLAG] = 1'b0;
      end
      if (conv_ok && limits_i.os_out) begin
        stat2_d[STAT2_OVERTEMP_SHUTDOWN_FLAG] = 1'b1;
      end
    end else if (conv_ok) begin
      stat2_d[STAT2_OVERTEMP_SHUTDOWN_FLAG] = limits_i.os_out;
    end
    if (temp_sticky) begin
      if (rd_stat2) begin
        stat2_d[STAT2_TEMP_BIT] = 1'b0;
      end
      if (conv_ok && limits_i.temp_out) begin
        stat2_d[STAT2_TEMP_BIT] = 1'b1;
      end
    end else if (conv_ok) begin
      stat2_d[STAT2_TEMP_BIT] = limits_i.temp_out;
    end
    if (chclr_busy || chclr_start) begin
      stat2_d[STAT2_INTR_BIT] = 1'b0;
    end
    // intrusion latch set, wins over clear
    if (intrusion_high) begin
      stat2_d[STAT2_INTR_BIT] = 1'b1;
    end
    if (fan_over[1]) begin
      stat2_d[STAT2_FAN2_BIT] = 1'b1;
    end
    if (fan_over[0]) begin
      stat2_d[STAT2_FAN1_BIT] = 1'b1;
    end
    if (bti_low) begin
      stat2_d[STAT2_BTI_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stat2_q <= STAT_RESET[STAT2_USED_W-1:0];
    end else begin
      stat2_q <= stat2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] cfg_view;

  // Chassis-clear bit reads as set for the whole window
  always_comb begin
    cfg_view = cfg_q;
    cfg_view[CFG_CHCLR_BIT] = cfg_q[CFG_CHCLR_BIT] || chclr_busy;
  end

  // Unmapped offsets read zero; data holds between reads
  always_comb begin
    rdata_d = rdata_q;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        CFG_OFFSET:   rdata_d = cfg_view;
        STAT1_OFFSET: rdata_d = stat1_q;
        STAT2_OFFSET: rdata_d = {2'h0, stat2_q};
        default:      rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Output pins

  logic pending;
  logic alert_act;
  logic alert_q;
  logic alert_d;
  logic gpo_q;
  logic gpo_d;
  logic rst_out_q;
  logic rst_out_d;

  assign pending = |(stat1_q & ~mask_volt_i)
                   || |(stat2_q & ~mask_therm_i[STAT2_USED_W-1:0]);

  assign alert_act = pending && cfg_q[CFG_EN_BIT] && !cfg_q[CFG_SUPP_BIT];

  always_comb begin
    alert_d   = cfg_q[CFG_POL_BIT] ? alert_act : !alert_act;
    gpo_d     = !cfg_q[CFG_GPO_BIT];
    rst_out_d = !rstp_busy;
  end

  // Registered so pins never glitch on mask or status changes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      alert_q   <= 1'b1;
      gpo_q     <= 1'b1;
      rst_out_q <= 1'b1;
    end else begin
      alert_q   <= alert_d;
      gpo_q     <= gpo_d;
      rst_out_q <= rst_out_d;
    end
  end

  assign alert_o              = alert_q;
  assign general_output_pin_o = gpo_q;
  assign reset_out_n_o        = rst_out_q;

endmodule

/* File: tb/mcs_host_model.sv */
// Host controller stand-in issuing single-byte register requests
`timescale 1ns/1ps
module mcs_host_model
  import mcs_pkg::*;
(
  // Clock
  input  wire logic       sys_clk_i,
  // Register port
  input  wire logic [7:0] rdata_i,
  output mcs_reg_req_type req_o
);
  initial req_o = '0;

  // Idle lines carry the inverse of the last byte, so stale data never helps
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    req_o = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk_i);
    req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask

  // Read data is taken one cycle after the request edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    req_o = '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk_i);
    req_o = '{1'b0, 1'b0, ~a, 8'hFF};
    d = rdata_i;
  endtask
endmodule

/* File: tb/mcs_regs_chk.sv */
// Port-level assertions for the configuration/status registers
`timescale 1ns/1ps
module mcs_regs_chk
  import mcs_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
  input wire logic            sys_clk_i,
  input wire logic            rst_i,
  input wire mcs_reg_req_type reg_req_i,
  input wire logic [7:0]      reg_rdata_o,
  input wire logic            alert_o,
  input wire logic            general_output_pin_o,
  input wire logic            reset_out_n_o,
  input wire logic            volt_temp_run_o,
  input wire logic            fan_run_o,
  input wire logic            defaults_restore_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int unsigned low_q;
  int unsigned low_d;

  // Length of the current low phase of the reset output
  always_comb begin
    low_d = reset_out_n_o ? 0 : low_q + 1;
  end
  always_ff @(posedge sys_clk_i) begin
    low_q <= rst_i ? 0 : low_d;
  end

  restore_pulse_a: assert property (
    reg_req_i.wr && reg_req_i.addr == CFG_OFFSET && reg_req_i.wdata[7]
    |=> defaults_restore_o && !fan_run_o && !volt_temp_run_o)
    else $error("restore pulse or defaults missing");
  restore_cause_a: assert property (
    defaults_restore_o |-> $past(reg_req_i.wr && reg_req_i.wdata[7]))
    else $error("restore pulse without restore write");
  gpo_level_a: assert property (
    (reg_req_i.wr && reg_req_i.addr == CFG_OFFSET && !reg_req_i.wdata[7])
    ##1 !reg_req_i.wr |-> ##1
    general_output_pin_o == !$past(reg_req_i.wdata[6], 2))
    else $error("general output pin level wrong");
  rst_cause_a: assert property (
    $fell(reset_out_n_o) |-> $past(reg_req_i.wr && reg_req_i.wdata[4]
    && reg_req_i.addr == CFG_OFFSET, 2))
    else $error("reset pulse without cause");
  rst_len_a: assert property (
    $rose(reset_out_n_o) |-> low_q >= PULSE_LEN)
    else $error("reset pulse too short");
  alert_idle_a: assert property (
    (reg_req_i.wr && reg_req_i.addr == CFG_OFFSET && !reg_req_i.wdata[7]
    && (!reg_req_i.wdata[1] || reg_req_i.wdata[3])) ##1 !reg_req_i.wr
    |-> ##1 alert_o == !$past(reg_req_i.wdata[2], 2))
    else $error("disabled alert not at idle level");
  run_ctl_a: assert property (
    reg_req_i.wr && reg_req_i.addr == CFG_OFFSET && !reg_req_i.wdata[7]
    |=> fan_run_o == $past(reg_req_i.wdata[0]) && volt_temp_run_o ==
    ($past(reg_req_i.wdata[0]) && !$past(reg_req_i.wdata[3])))
    else $error("monitoring run outputs wrong");
  resv_zero_a: assert property (
    reg_req_i.rd && reg_req_i.addr == STAT2_OFFSET
    |=> reg_rdata_o[7:6] == 2'b00)
    else $error("reserved status bits not zero");
  // Unmapped reads
  unmapped_a: assert property (
    reg_req_i.rd && reg_req_i.addr > STAT2_OFFSET |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind mcs_regs mcs_regs_chk #(.PULSE_LEN(PULSE_LEN)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .alert_o(alert_o),
  .general_output_pin_o(general_output_pin_o),
  .reset_out_n_o(reset_out_n_o), .volt_temp_run_o(volt_temp_run_o),
  .fan_run_o(fan_run_o), .defaults_restore_o(defaults_restore_o)
);

/* File: tb/mcs_regs_test.sv */
// Self-checking bench for the configuration/status registers
`timescale 1ns/1ps
module mcs_regs_test
  import mcs_pkg::*;
;
  localparam int unsigned PL = 20;
  logic            sys_clk_i, rst_i, alert_n, intr, bti_n;
  logic            alert, general_output_pin, rst_n, vt_run, f_run, restore;
  mcs_reg_req_type req;
  mcs_limit_type   lim;
  logic [7:0]      rdata, mask_v, mask_t, pin_cfg;
  logic [1:0]      fan_v;
  logic [1:0][7:0] fan_c, fan_l;
  int              errors, checked;

  mcs_host_model u_host (.sys_clk_i(sys_clk_i), .rdata_i(rdata),
    .req_o(req));
  mcs_regs #(.PULSE_LEN(PL), .FAN_W(8)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .mask_volt_i(mask_v), .mask_therm_i(mask_t),
    .pin_cfg_i(pin_cfg), .limits_i(lim), .fan_valid_i(fan_v),
    .fan_count_i(fan_c), .fan_limit_i(fan_l), .alert_in_n_i(alert_n),
    .intrusion_input_i(intr), .board_temp_alert_n_i(bti_n),
    .alert_o(alert), .general_output_pin_o(general_output_pin), .reset_out_n_o(rst_n),
    .volt_temp_run_o(vt_run), .fan_run_o(f_run),
    .defaults_restore_o(restore));

  // Clock at 100 ns
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Pin snapshot: alert, gpo, reset out, volt/temp run, fan run
  function automatic logic [7:0] pins();
    return {3'h0, alert, general_output_pin, rst_n, vt_run, f_run};
  endfunction

  // One conversion result; only the valid pulse matters once it drops
  task automatic conv(input logic [6:0] v, input logic t, input logic o);
    @(negedge sys_clk_i);
    lim = '{1'b1, v, t, o};
    @(negedge sys_clk_i);
    lim = '{1'b0, ~v, ~t, ~o};
    cyc(2);
  endtask

  task automatic fan(input logic [7:0] c1, input logic [7:0] c0);
    fan_c = {c1, c0};
    fan_v = 2'b11;
    cyc(1);
    fan_v = 2'b00;
    cyc(2);
  endtask

  // Watchdog sized well above the sequence length
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    errors++;
    test_done();
  end

  initial begin
    errors = 0;
    checked = 0;
    rst_i = 1'b1;
    {alert_n, intr, bti_n} = 3'b101;
    {mask_v, mask_t, pin_cfg} = {8'h00, 8'h00, 8'h80};
    lim = '0;
    fan_v = 2'b00;
    fan_c = '0;
    fan_l = {8'h10, 8'h10};
    cyc(5);
    rst_i = 1'b0;
    chk(pins(), 8'h1C);
    rdc(CFG_OFFSET, CFG_RESET);
    rdc(STAT1_OFFSET, STAT_RESET);
    rdc(STAT2_OFFSET, STAT_RESET);
    rdc(8'h3E, 8'h00);
    u_host.wr(CFG_OFFSET, 8'h03);
    conv(7'h41, 1'b0, 1'b0);
    chk(pins(), 8'h0F);
    rdc(STAT1_OFFSET, 8'h41);
    cyc(2);
    chk(pins(), 8'h1F);
    mask_v = 8'hFF;
    conv(7'h7F, 1'b0, 1'b0);
    chk(pins(), 8'h1F);
    rdc(STAT1_OFFSET, 8'h7F);
    mask_v = 8'h00;
    u_host.wr(CFG_OFFSET, 8'h07);
    cyc(2);
    chk(pins(), 8'h0F);
    conv(7'h01, 1'b0, 1'b0);
    chk(pins(), 8'h1F);
    rdc(STAT1_OFFSET, 8'h01);
    alert_n = 1'b0;
    cyc(5);
    alert_n = 1'b1;
    cyc(4);
    rdc(STAT1_OFFSET, 8'h80);
    rdc(STAT1_OFFSET, 8'h00);
    u_host.wr(CFG_OFFSET, 8'h0F);
    // Leave a status bit pending so a broken suppress would show
    alert_n = 1'b0;
    cyc(3);
    alert_n = 1'b1;
    conv(7'h7F, 1'b1, 1'b1);
    chk(pins(), 8'h0D);
    rdc(STAT1_OFFSET, 8'h80);
    u_host.wr(CFG_OFFSET, 8'h05);
    conv(7'h01, 1'b0, 1'b0);
    chk(pins(), 8'h0F);
    rdc(STAT1_OFFSET, 8'h01);
    u_host.wr(CFG_OFFSET, 8'h00);
    conv(7'h01, 1'b0, 1'b0);
    chk(pins(), 8'h1C);
    rdc(STAT1_OFFSET, 8'h00);
    u_host.wr(CFG_OFFSET, 8'h01);
    fan(8'h10, 8'h11);
    rdc(STAT2_OFFSET, 8'h04);
    fan(8'h11, 8'h10);
    rdc(STAT2_OFFSET, 8'h08);
    conv(7'h00, 1'b1, 1'b1);
    rdc(STAT2_OFFSET, 8'h21);
    rdc(STAT2_OFFSET, 8'h21);
    conv(7'h00, 1'b0, 1'b0);
    rdc(STAT2_OFFSET, 8'h00);
    mask_t = 8'hC0;
    conv(7'h00, 1'b1, 1'b1);
    conv(7'h00, 1'b0, 1'b0);
    rdc(STAT2_OFFSET, 8'h21);
    rdc(STAT2_OFFSET, 8'h00);
    u_host.wr(STAT2_OFFSET, 8'hFF);
    rdc(STAT2_OFFSET, 8'h00);
    bti_n = 1'b0;
    cyc(4);
    bti_n = 1'b1;
    cyc(4);
    rdc(STAT2_OFFSET, 8'h02);
    intr = 1'b1;
    cyc(4);
    intr = 1'b0;
    cyc(4);
    rdc(STAT2_OFFSET, 8'h10);
    rdc(STAT2_OFFSET, 8'h10);
    u_host.wr(CFG_OFFSET, 8'h21);
    rdc(CFG_OFFSET, 8'h21);
    cyc(PL);
    rdc(CFG_OFFSET, 8'h01);
    rdc(STAT2_OFFSET, 8'h00);
    u_host.wr(CFG_OFFSET, 8'h41);
    cyc(2);
    chk(pins(), 8'h17);
    u_host.wr(CFG_OFFSET, 8'h11);
    cyc(2);
    chk(pins(), 8'h1B);
    rdc(CFG_OFFSET, 8'h11);
    cyc(PL);
    rdc(CFG_OFFSET, 8'h01);
    chk(pins(), 8'h1F);
    pin_cfg = 8'hC0;
    u_host.wr(CFG_OFFSET, 8'h11);
    cyc(PL + 4);
    rdc(CFG_OFFSET, 8'h11);
    u_host.wr(CFG_OFFSET, 8'hC7);
    chk({7'h00, restore}, 8'h01);
    rdc(CFG_OFFSET, CFG_RESET);
    chk(pins(), 8'h1C);
    test_done();
  end
endmodule
